/* hdl/usb_serial_port.sv */
// Purpose: serial data buffer with transmit shifter and receive latch
// Assumes: register access is a plain SFR port, synchronous to CLK_SYS
// Notes:   10-bit frame, start, 8 data LSB first, stop; ninth bit optional
`timescale 1ns/10ps
`include "usb_defs.svh"

// Overview of operation
// RQ1 - one data buffer address: write reaches transmit shifter, read the latch
// RQ2 - written byte sits in the transmit shifter until fully sent; here a write mid-frame replaces it and restarts
// RQ3 - every write starts a transmission with no other command
// RQ4 - reads return the receive latch, never the transmit byte
// RQ5 - software picks reload 0x96 settings for 115200 or 9600 at 24.5 MHz
// RQ6 - software picks reload 0xD0 or 0xFA settings for 230400 at 22.1184 MHz
// RQ7 - prescale select picks /12, /4, /48 or external /8; direct bit overrides
// RQ8 - bit period is prescale times two times (256 minus reload)
// RQ9 - transmit complete flag sets at start of stop bit
// RQ10 - received byte latched after stop only if receive flag clear and filter passes
module usb_serial_port
(
    input  wire logic       CLK_SYS,
    input  wire logic       SYS_RST,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic [3:0] SFR_PAGE,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       BAUD_TIMER_DIRECT_CLOCK_SELECT,
    input  wire logic [1:0] TIMER_PRESCALE_SELECT,
    input  wire logic [7:0] BAUD_TIMER_RELOAD,
    input  wire logic       EXTERNAL_OSCILLATOR_CLOCK,
    input  wire logic       RECEIVE_ENABLE,
    input  wire logic       NINE_BIT_MODE,
    input  wire logic       TRANSMIT_NINTH_BIT,
    input  wire logic       MULTIPROCESSOR_FILTER_ENABLE,
    input  wire logic       TRANSMIT_FLAG_CLEAR,
    input  wire logic       RECEIVE_FLAG_CLEAR,
    output logic            TRANSMIT_COMPLETE_FLAG,
    output logic            RECEIVE_COMPLETE_FLAG,
    output logic            RECEIVED_NINTH_BIT,
    output logic            TRANSMIT_BUSY,
    input  wire logic       SERIAL_RX,
    output logic            SERIAL_TX
);

    usb_pkg::usb_baud_cfg_type baud_cfg;
    usb_pkg::usb_tx_state_type tx_state_ff, nxt_tx_state;
    usb_pkg::usb_rx_state_type rx_state_ff, nxt_rx_state;
    logic [8:0] tx_shift_ff, nxt_tx_shift;
    logic [3:0] tx_bit_ff, nxt_tx_bit;
    logic       tx_line_ff, nxt_tx_line;
    logic       ti_ff, nxt_ti;
    logic [8:0] rx_shift_ff, nxt_rx_shift;
    logic [3:0] rx_bit_ff, nxt_rx_bit;
    logic [7:0] rx_latch_ff, nxt_rx_latch;
    logic       ri_ff, nxt_ri;
    logic       rb8_ff, nxt_rb8;
    logic       rx_half_ff, nxt_rx_half;
    logic       rx_sample;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       half_tick;
    logic       bit_tick;
    logic       sel;
    logic       wr_buf;
    logic [3:0] data_bits;
    logic       rx_accept;

    // one address, split by direction
    assign sel       = (SFR_ADDR == `USB_SBUF_ADDR) && (SFR_PAGE == `USB_SBUF_PAGE); // RQ1
    assign wr_buf    = sel && SFR_WR; // RQ1
    assign data_bits = NINE_BIT_MODE ? 4'h9 : 4'h8;
    assign baud_cfg  = '{direct_clock: BAUD_TIMER_DIRECT_CLOCK_SELECT,
                         prescale_select: TIMER_PRESCALE_SELECT,
                         reload: BAUD_TIMER_RELOAD};

    usb_baud_gen u_baud
    (
        .clk       (CLK_SYS),
        .rst       (SYS_RST),
        .cfg       (baud_cfg),
        .ext_clk   (EXTERNAL_OSCILLATOR_CLOCK),
        .half_tick (half_tick),
        .bit_tick  (bit_tick)
    );

    // transmitter; a write mid-frame restarts with the new byte
    always_comb
    begin
        nxt_tx_state = tx_state_ff;
        nxt_tx_shift = tx_shift_ff;
        nxt_tx_bit   = tx_bit_ff;
        nxt_tx_line  = tx_line_ff;
        nxt_ti       = ti_ff && !TRANSMIT_FLAG_CLEAR;
        if (wr_buf)
        begin
            nxt_tx_shift = {TRANSMIT_NINTH_BIT, SFR_WDATA}; // RQ2
            nxt_tx_bit   = 4'h0;
            nxt_tx_state = usb_pkg::TX_SHIFT; // RQ3
        end
        else if (bit_tick)
        begin
            unique case (tx_state_ff)
                usb_pkg::TX_IDLE:  nxt_tx_line = 1'b1;
                usb_pkg::TX_SHIFT:
                begin
                    // start waits for a tick so it lasts one whole bit period
                    if (tx_bit_ff == 4'h0)
                    begin
                        nxt_tx_line = 1'b0; // RQ8
                        nxt_tx_bit  = 4'h1;
                    end
                    else if (tx_bit_ff == data_bits + 4'h1)
                    begin
                        nxt_tx_line  = 1'b1;
                        nxt_tx_state = usb_pkg::TX_STOP;
                        nxt_ti       = 1'b1; // RQ9
                    end
                    else
                    begin
                        nxt_tx_line  = tx_shift_ff[0];
                        nxt_tx_shift = {1'b1, tx_shift_ff[8:1]}; // RQ2
                        nxt_tx_bit   = tx_bit_ff + 4'h1;
                    end
                end
                usb_pkg::TX_STOP:  nxt_tx_state = usb_pkg::TX_IDLE;
                default:           nxt_tx_state = usb_pkg::TX_IDLE;
            endcase
        end
    end

    // receiver; every second half tick after the start check samples,
    // so sampling follows the start edge, not the free-running bit tick
    always_comb
    begin
        nxt_rx_state = rx_state_ff;
        nxt_rx_shift = rx_shift_ff;
        nxt_rx_bit   = rx_bit_ff;
        nxt_rx_latch = rx_latch_ff;
        nxt_rb8      = rb8_ff;
        nxt_ri       = ri_ff && !RECEIVE_FLAG_CLEAR;
        nxt_rx_half  = half_tick ? !rx_half_ff : rx_half_ff;
        rx_sample    = half_tick && rx_half_ff;
        rx_accept    = !ri_ff && (!MULTIPROCESSOR_FILTER_ENABLE ||
                        (NINE_BIT_MODE ? rx_shift_ff[8] : SERIAL_RX)); // RQ10
        unique case (rx_state_ff)
            usb_pkg::RX_IDLE:
                if (RECEIVE_ENABLE && !SERIAL_RX)
                begin
                    nxt_rx_state = usb_pkg::RX_START;
                end
            usb_pkg::RX_START:
                if (half_tick)
                begin
                    nxt_rx_state = SERIAL_RX ? usb_pkg::RX_IDLE : usb_pkg::RX_DATA;
                    nxt_rx_bit   = 4'h0;
                    nxt_rx_half  = 1'b0;
                end
            usb_pkg::RX_DATA:
                if (rx_sample)
                begin
                    nxt_rx_shift = {SERIAL_RX, rx_shift_ff[8:1]};
                    nxt_rx_bit   = rx_bit_ff + 4'h1;
                    if (rx_bit_ff + 4'h1 == data_bits)
                    begin
                        nxt_rx_state = usb_pkg::RX_STOP;
                    end
                end
            usb_pkg::RX_STOP:
                if (rx_sample)
                begin
                    nxt_rx_state = usb_pkg::RX_IDLE;
                    if (rx_accept)
                    begin
                        nxt_rx_latch = NINE_BIT_MODE ? rx_shift_ff[7:0] : rx_shift_ff[8:1];
                        nxt_rb8      = NINE_BIT_MODE ? rx_shift_ff[8] : SERIAL_RX;
                        nxt_ri       = 1'b1; // RQ10
                    end
                end
        endcase
        // read returns latch, registered for a clean data output
        nxt_rdata = (sel && SFR_RD) ? nxt_rx_latch : rdata_ff; // RQ4
    end

    // all state registers
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            tx_state_ff <= usb_pkg::TX_IDLE;
            tx_shift_ff <= 9'h1FF;
            tx_bit_ff   <= 4'h0;
            tx_line_ff  <= 1'b1;
            ti_ff       <= 1'b0;
            rx_state_ff <= usb_pkg::RX_IDLE;
            rx_shift_ff <= 9'h000;
            rx_bit_ff   <= 4'h0;
            rx_latch_ff <= `USB_SBUF_RESET;
            ri_ff       <= 1'b0;
            rb8_ff      <= 1'b0;
            rx_half_ff  <= 1'b0;
            rdata_ff    <= `USB_SBUF_RESET;
        end
        else
        begin
            tx_state_ff <= nxt_tx_state;
            tx_shift_ff <= nxt_tx_shift;
            tx_bit_ff   <= nxt_tx_bit;
            tx_line_ff  <= nxt_tx_line;
            ti_ff       <= nxt_ti;
            rx_state_ff <= nxt_rx_state;
            rx_shift_ff <= nxt_rx_shift;
            rx_bit_ff   <= nxt_rx_bit;
            rx_latch_ff <= nxt_rx_latch;
            ri_ff       <= nxt_ri;
            rb8_ff      <= nxt_rb8;
            rx_half_ff  <= nxt_rx_half;
            rdata_ff    <= nxt_rdata;
        end
    end

    assign SFR_RDATA              = rdata_ff;
    assign SERIAL_TX              = tx_line_ff;
    assign TRANSMIT_COMPLETE_FLAG = ti_ff;
    assign RECEIVE_COMPLETE_FLAG  = ri_ff;
    assign RECEIVED_NINTH_BIT     = rb8_ff;
    assign TRANSMIT_BUSY          = (tx_state_ff != usb_pkg::TX_IDLE);

    // write arms the frame: busy next cycle with the start bit pending
    a_write_starts_tx: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ3
        wr_buf |=> (TRANSMIT_BUSY && tx_bit_ff == 4'h0))
        else $error("write did not start transmission");

    // start bit launched on a bit tick, so it lasts a full bit period
    a_start_on_tick: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ8
        (bit_tick && !wr_buf && tx_state_ff == usb_pkg::TX_SHIFT && tx_bit_ff == 4'h0)
        |=> !SERIAL_TX)
        else $error("start bit not launched on bit tick");

    // completion flag rises only at the stop bit
    a_ti_at_stop: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ9
        $rose(ti_ff) |-> (tx_state_ff == usb_pkg::TX_STOP && SERIAL_TX))
        else $error("transmit flag set outside stop bit");

    // latch only loads when receive flag was clear
    a_latch_guard: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ10
        $past(ri_ff) && !$past(RECEIVE_FLAG_CLEAR) |-> $stable(rx_latch_ff))
        else $error("receive latch overwritten while flag set");

    // read returns latch, not the transmit byte
    a_read_latch: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ4
        (sel && SFR_RD) |=> (SFR_RDATA == rx_latch_ff))
        else $error("read did not return receive latch");

    // written byte sits in the transmit shifter the cycle after the write
    a_tx_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RQ2
        wr_buf |=> (tx_shift_ff[7:0] == $past(SFR_WDATA)))
        else $error("written byte not in transmit shifter");

endmodule

/* hdl/usb_defs.svh */
// Purpose: constants for the serial data buffer and baud setup block
// Assumes: included by bare name from hdl files
// Notes:   offsets, select codes, prescale values, reset values and timing counts
`ifndef USB_DEFS_SVH
`define USB_DEFS_SVH

`define USB_SBUF_ADDR        8'h99
`define USB_SBUF_PAGE        4'h0
`define USB_SBUF_RESET       8'h00
`define USB_DIV_SYS12        2'h0
`define USB_DIV_SYS4         2'h1
`define USB_DIV_SYS48        2'h2
`define USB_DIV_EXT8         2'h3
`define USB_PRE_12           6'h0C
`define USB_PRE_4            6'h04
`define USB_PRE_48           6'h30
`define USB_PRE_8            6'h08
`define USB_PRE_1            6'h01
`define USB_TIMER_TOP        9'h100
`define USB_FRAME_BITS       4'hA

`endif

/* hdl/usb_pkg.sv */
// Purpose: shared types for the serial data buffer block
// Assumes: nothing beyond the defs header
// Notes:   states and the baud configuration carrier
package usb_pkg;

    typedef enum logic [1:0]
    {
        TX_IDLE  = 2'b00,
        TX_SHIFT = 2'b01,
        TX_STOP  = 2'b10
    } usb_tx_state_type;

    typedef enum logic [1:0]
    {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } usb_rx_state_type;

    typedef struct packed
    {
        logic       direct_clock;
        logic [1:0] prescale_select;
        logic [7:0] reload;
    } usb_baud_cfg_type;

endpackage

/* hdl/usb_baud_gen.sv */
// Purpose: baud tick generator, prescaler plus 8-bit auto-reload timer
// Assumes: external clock arrives already synchronous to CLK_SYS
// Notes:   bit_tick pulses once per bit period, half_tick once per half
`timescale 1ns/10ps
`include "usb_defs.svh"

module usb_baud_gen
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire usb_pkg::usb_baud_cfg_type cfg,
    input  wire logic                      ext_clk,
    output logic                           half_tick,
    output logic                           bit_tick
);

    logic [5:0] pre_cnt_ff;
    logic [5:0] nxt_pre_cnt;
    logic [8:0] tmr_cnt_ff;
    logic [8:0] nxt_tmr_cnt;
    logic       half_ff;
    logic       nxt_half;
    logic       ext_q_ff;
    logic       nxt_ext_q;
    logic [5:0] pre_div;
    logic       src_ev;
    logic       tmr_ev;
    logic       ovf;

    // prescale choice; direct select overrides the field
    always_comb
    begin
        unique case (cfg.prescale_select)
            `USB_DIV_SYS12: pre_div = `USB_PRE_12;
            `USB_DIV_SYS4:  pre_div = `USB_PRE_4;
            `USB_DIV_SYS48: pre_div = `USB_PRE_48;
            `USB_DIV_EXT8:  pre_div = `USB_PRE_8;
        endcase
        if (cfg.direct_clock)
        begin
            pre_div = `USB_PRE_1; // RQ7
        end
    end

    // external clock counts rising edges, system clock counts cycles
    always_comb
    begin
        nxt_ext_q = ext_clk;
        src_ev    = 1'b1;
        if (!cfg.direct_clock && cfg.prescale_select == `USB_DIV_EXT8)
        begin
            src_ev = ext_clk && !ext_q_ff; // RQ7
        end
        nxt_pre_cnt = pre_cnt_ff;
        tmr_ev      = 1'b0;
        if (src_ev)
        begin
            if (pre_cnt_ff + 6'h01 >= pre_div)
            begin
                nxt_pre_cnt = 6'h00;
                tmr_ev      = 1'b1;
            end
            else
            begin
                nxt_pre_cnt = pre_cnt_ff + 6'h01;
            end
        end
        // timer counts reload..255, overflow reloads; two overflows per bit
        ovf         = tmr_ev && (tmr_cnt_ff[7:0] == 8'hFF); // RQ8
        nxt_tmr_cnt = tmr_cnt_ff;
        if (ovf)
        begin
            nxt_tmr_cnt = {1'b0, cfg.reload};
        end
        else if (tmr_ev)
        begin
            nxt_tmr_cnt = tmr_cnt_ff + 9'h001;
        end
        nxt_half  = ovf ? !half_ff : half_ff;
        half_tick = ovf;
        bit_tick  = ovf && half_ff; // RQ8
    end

    // timer and prescaler state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pre_cnt_ff <= 6'h00;
            tmr_cnt_ff <= 9'h000;
            half_ff    <= 1'b0;
            ext_q_ff   <= 1'b0;
        end
        else
        begin
            pre_cnt_ff <= nxt_pre_cnt;
            tmr_cnt_ff <= nxt_tmr_cnt;
            half_ff    <= nxt_half;
            ext_q_ff   <= nxt_ext_q;
        end
    end

endmodule

/* test/usb_far_end.sv */
// Purpose: remote serial transceiver on the far side of the link
// Assumes: bit period given in CLK_SYS cycles; line idles high
// Notes:   drives and samples on the falling edge, clear of design updates
`timescale 1ns/10ps

module usb_far_end
(
    input  wire logic clk,
    input  wire logic tx_line,
    output logic      rx_line
);
    // mark level between frames, as a pulled-up line would show
    initial rx_line = 1'h1;

    // start, data lsb first, ninth bit or extra stop, stop
    task automatic send_frame(input logic [7:0] data, input logic nine, input logic ninth,
                              input int per);
        logic [10:0] bits;
        bits = {1'h1, nine ? ninth : 1'h1, data, 1'h0};
        for (int i = 0; i < 11; i++)
        begin
            @(negedge clk);
            rx_line = bits[i];
            repeat (per - 1) @(negedge clk);
        end
    endtask

    // mid-bit sampling keeps us clear of timer phase jitter
    task automatic recv_frame(output logic [7:0] data, output logic ok, input int per);
        int n;
        n  = 0;
        ok = 1'h0;
        while (tx_line !== 1'h0 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        ok = (n < 5000);
        repeat (per / 2) @(negedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (per) @(negedge clk);
            data[i] = tx_line;
        end
    endtask
endmodule

/* test/tb_top.sv */
// Purpose: self-checking bench for the serial data buffer block
// Assumes: short bit periods through large reload values such as 0xFE
// Notes:   inputs change on the falling edge; results are read there too
`timescale 1ns/10ps

module tb_top;
    logic                      clk_sys;
    logic                      sys_rst;
    logic [7:0]                addr;
    logic [3:0]                page;
    logic                      wr;
    logic                      rd;
    logic [7:0]                wdata;
    logic [7:0]                rdata;
    usb_pkg::usb_baud_cfg_type cfg;
    logic                      ext_clk;
    logic                      nine;
    logic                      mpf;
    logic                      tclr;
    logic                      rclr;
    logic                      tflag;
    logic                      rflag;
    logic                      rx9;
    logic                      busy;
    logic                      serial_rx;
    logic                      serial_tx;
    logic [7:0]                got;
    logic                      ok;
    int                        n;
    int                        exp;
    int                        miscompares;
    int                        comparisons;
    usb_pkg::usb_baud_cfg_type cfgs [7];

    usb_serial_port i_dut
    (
        .CLK_SYS                        (clk_sys),
        .SYS_RST                        (sys_rst),
        .SFR_ADDR                       (addr),
        .SFR_PAGE                       (page),
        .SFR_WR                         (wr),
        .SFR_RD                         (rd),
        .SFR_WDATA                      (wdata),
        .SFR_RDATA                      (rdata),
        .BAUD_TIMER_DIRECT_CLOCK_SELECT (cfg.direct_clock),
        .TIMER_PRESCALE_SELECT          (cfg.prescale_select),
        .BAUD_TIMER_RELOAD              (cfg.reload),
        .EXTERNAL_OSCILLATOR_CLOCK      (ext_clk),
        .RECEIVE_ENABLE                 (1'h1),
        .NINE_BIT_MODE                  (nine),
        .TRANSMIT_NINTH_BIT             (1'h0),
        .MULTIPROCESSOR_FILTER_ENABLE   (mpf),
        .TRANSMIT_FLAG_CLEAR            (tclr),
        .RECEIVE_FLAG_CLEAR             (rclr),
        .TRANSMIT_COMPLETE_FLAG         (tflag),
        .RECEIVE_COMPLETE_FLAG          (rflag),
        .RECEIVED_NINTH_BIT             (rx9),
        .TRANSMIT_BUSY                  (busy),
        .SERIAL_RX                      (serial_rx),
        .SERIAL_TX                      (serial_tx)
    );

    usb_far_end i_far
    (
        .clk     (clk_sys),
        .tx_line (serial_tx),
        .rx_line (serial_rx)
    );

    // 100 ns system clock; external clock at half rate, one rise per two cycles
    initial
    begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial ext_clk = 1'h0;
    always @(negedge clk_sys) ext_clk <= ~ext_clk;

    task automatic final_report;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp_byte(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask

    task automatic cmp_cnt(input int g, input int e);
        comparisons++;
        if (g != e)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask

    // bounded wait; running out ends the run as a failure
    task automatic wait_on(input int sel, input logic lvl, output int cnt);
        cnt = 0;
        while ((sel == 0 ? serial_tx : sel == 1 ? tflag : rflag) !== lvl && cnt < 20000)
        begin
            @(negedge clk_sys);
            cnt++;
        end
        if (cnt >= 20000)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, cnt, 20000);
            final_report();
        end
    endtask

    task automatic do_reset;
        sys_rst = 1'h1;
        repeat (6) @(negedge clk_sys);
        sys_rst = 1'h0;
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
        @(negedge clk_sys);
        addr  = a;
        page  = p;
        wdata = d;
        wr    = 1'h1;
        @(negedge clk_sys);
        wr = 1'h0;
    endtask

    task automatic sfr_read(output logic [7:0] d);
        @(negedge clk_sys);
        addr = 8'h99;
        page = 4'h0;
        rd   = 1'h1;
        @(negedge clk_sys);
        rd = 1'h0;
        @(negedge clk_sys);
        d = rdata;
    endtask

    task automatic clear_flags;
        @(negedge clk_sys);
        tclr = 1'h1;
        rclr = 1'h1;
        @(negedge clk_sys);
        tclr = 1'h0;
        rclr = 1'h0;
    endtask

    // main sequence; bit period 4 clocks unless the table says otherwise
    initial
    begin
        {addr, page, wr, rd, wdata, nine, mpf, tclr, rclr} = '0;
        miscompares = 0;
        comparisons = 0;
        cfg = {1'h1, 2'h0, 8'hFE};
        cfgs = '{{1'h1, 2'h0, 8'h96}, {1'h0, 2'h0, 8'h96}, {1'h1, 2'h0, 8'hD0},
                 {1'h0, 2'h3, 8'hFA}, {1'h0, 2'h1, 8'hFF}, {1'h0, 2'h2, 8'hFF},
                 {1'h1, 2'h2, 8'hFE}};
        do_reset();
        sfr_read(got);
        cmp_byte(got, 8'h00);
        sfr_write(8'h98, 4'h0, 8'h5A);
        sfr_write(8'h99, 4'h1, 8'h5A);
        repeat (8) @(negedge clk_sys);
        cmp_byte({6'h0, serial_tx, busy}, 8'h02);
        fork
            i_far.recv_frame(got, ok, 4);
            sfr_write(8'h99, 4'h0, 8'hA5);
        join
        cmp_byte({ok, got}, {1'h1, 8'hA5});
        wait_on(1, 1'h1, n);
        cmp_byte({6'h0, serial_tx, busy}, 8'h03);
        clear_flags();
        // receive path: latch, not the byte just sent
        i_far.send_frame(8'h3C, 1'h0, 1'h0, 4);
        wait_on(2, 1'h1, n);
        sfr_read(got);
        cmp_byte(got, 8'h3C);
        // flag still set, so this byte must be dropped
        i_far.send_frame(8'h99, 1'h0, 1'h0, 4);
        repeat (8) @(negedge clk_sys);
        sfr_read(got);
        cmp_byte(got, 8'h3C);
        clear_flags();
        nine = 1'h1;
        mpf  = 1'h1;
        i_far.send_frame(8'h77, 1'h1, 1'h0, 4);
        repeat (8) @(negedge clk_sys);
        cmp_byte({7'h0, rflag}, 8'h00);
        i_far.send_frame(8'h77, 1'h1, 1'h1, 4);
        wait_on(2, 1'h1, n);
        sfr_read(got);
        cmp_byte({rx9, got}, {1'h1, 8'h77});
        // bit width of a lone high data bit under each timer setting
        for (int i = 0; i < 7; i++)
        begin
            cfg = cfgs[i];
            do_reset();
            sfr_write(8'h99, 4'h0, 8'h05);
            wait_on(0, 1'h0, n);
            wait_on(0, 1'h1, n);
            wait_on(0, 1'h0, n);
            exp = cfg.direct_clock ? 1 : cfg.prescale_select == 2'h0 ? 12 :
                  cfg.prescale_select == 2'h1 ? 4 : cfg.prescale_select == 2'h2 ? 48 : 16;
            cmp_cnt(n, exp * 2 * (256 - cfg.reload));
        end
        final_report();
    end
endmodule
